//--- bench/rasq_host.sv
// Behavioural bus host that presents address bytes and observed bytes
`default_nettype none
module rasq_host (
	input wire logic clk_sys,
	output logic addrByteValid,
	output logic [7:0] addrByte,
	output logic obsByteValid,
	output logic [7:0] obsByte
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle bus shows no stale byte
	initial begin
		addrByteValid = 1'b0;
		addrByte = 8'h5a;
		obsByteValid = 1'b0;
		obsByte = 8'ha5;
	end

	// One address byte, direction in the low bit
	task automatic sendAddr(input logic [6:0] addr, input logic rd);
		@(posedge clk_sys);
		addrByteValid <= 1'b1;
		addrByte <= {addr, rd};
		@(posedge clk_sys);
		addrByteValid <= 1'b0;
		addrByte <= ~{addr, rd}; // Released bus must not look valid
	endtask : sendAddr

	// Byte seen on the wire during an alert reply
	task automatic sendObs(input logic [7:0] b);
		@(posedge clk_sys);
		obsByteValid <= 1'b1;
		obsByte <= b;
		@(posedge clk_sys);
		obsByteValid <= 1'b0;
		obsByte <= ~b;
	endtask : sendObs
endmodule : rasq_host
`default_nettype wire

//--- bench/test_rectifier_address_and_sequencing.sv
// Self-checking bench for the address and sequencing control block
`default_nettype none
module test_rectifier_address_and_sequencing;
	timeunit 1ns;
	timeprecision 100ps;
	import rasq_pkg::*;

	logic clk_sys, rst;
	logic [11:0] unitLevelMv, rackLevelMv, vprogLevelMv;
	logic protocolStrapPin, inputOkPin, inputBelow80Pin;
	logic voltCmdDone, alertEvent;
	logic addrByteValid, obsByteValid;
	logic [7:0] addrByte, obsByte, araByte;
	logic [3:0] addressSelectBits;
	logic addressValid, rs485Mode, addrAck, addrIsRead, invalidCmd;
	logic araReply, alertOe, useVprog, auxiliarySupplyOutput;
	logic mainEnable, mainRamping, powerGoodWarning, inputLed;
	int nFail, checksDone;

	rasq_host host (.clk_sys, .addrByteValid, .addrByte, .obsByteValid,
		.obsByte);

	// Short counts keep the run brief; start delay and auxiliary hold
	// keep their full length, far beyond the end of the run
	rasq_ctrl #(.LEAD_CYC(32'h14), .RAMP_LEN_CYC(32'ha),
		.HOLD_CYC(32'h1e), .WARN_CYC(32'h5), .BLINK_CYC(32'h4)) DUT (
		.clk_sys, .rst, .unitLevelMv, .rackLevelMv, .vprogLevelMv,
		.protocolStrapPin, .inputOkPin, .inputBelow80Pin, .addrByteValid,
		.addrByte, .voltCmdDone, .alertEvent, .obsByteValid, .obsByte,
		.addressSelectBits, .addressValid, .rs485Mode, .addrAck,
		.addrIsRead, .invalidCmd, .araReply, .araByte, .alertOe,
		.useVprog, .auxiliarySupplyOutput, .mainEnable, .mainRamping,
		.powerGoodWarning, .inputLed);

	// Free-running 250 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic finishTest;
		$display("Checks %0d, mismatches %0d", checksDone, nFail);
		if (nFail == 0 && checksDone > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finishTest

	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		checksDone++;
		if (seen !== exp) begin
			nFail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc

	function automatic logic pick(input int sel);
		case (sel)
			0: return auxiliarySupplyOutput;
			1: return mainEnable;
			2: return mainRamping;
			default: return powerGoodWarning;
		endcase
	endfunction : pick

	// Cycles until a watched output takes a value; bounded
	task automatic waitFor(input int sel, input logic val, output int n);
		n = 0;
		while (pick(sel) !== val) begin
			cyc(1);
			n++;
			if (n > 300) begin
				nFail++;
				$display("Error wait %0d expected %h seen %h", sel, val,
					pick(sel));
				finishTest();
			end
		end
	endtask : waitFor

	task automatic doReset;
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		cyc(30); // Capture plus pin synchronisers
	endtask : doReset

	// Invalid unit level first, then valid, then frozen configuration
	task automatic tConfig;
		check("addrValid", addressValid, 8'h0);
		host.sendAddr(7'h40, 1'b1);
		#1 check("ackUnset", addrAck, 8'h0);
		unitLevelMv <= 12'hbb8; // Unit 1
		cyc(30);
		check("addrValid", addressValid, 8'h1);
		check("selBits", addressSelectBits, 8'h0);
		check("mode", rs485Mode, 8'h0);
		rackLevelMv <= 12'h42e; // Rack 2 would give another address
		protocolStrapPin <= 1'b1;
		cyc(30);
		check("selHeld", addressSelectBits, 8'h0);
		check("modeHeld", rs485Mode, 8'h0);
		rackLevelMv <= 12'hcee;
		protocolStrapPin <= 1'b0;
	endtask : tConfig

	// Own, foreign, broadcast and alert-response address bytes
	task automatic tAddr;
		logic [6:0] ad [6] = '{7'h40, 7'h40, 7'h41, 7'h00, 7'h00, 7'h0c};
		logic [5:0] rd = 6'b101010;
		logic [5:0] ak = 6'b110100;
		logic [5:0] iv = 6'b000010;
		for (int i = 0; i < 6; i++) begin
			host.sendAddr(ad[i], rd[5-i]);
			#1 check("ack", addrAck, 8'(ak[5-i]));
			check("inval", invalidCmd, 8'(iv[5-i]));
			if (ak[5-i]) check("dir", addrIsRead, 8'(rd[5-i]));
		end
	endtask : tAddr

	// Alert released only by a matching observed byte
	task automatic tAlert;
		@(posedge clk_sys);
		alertEvent <= 1'b1;
		@(posedge clk_sys);
		alertEvent <= 1'b0;
		#1 check("alertSet", alertOe, 8'h1);
		for (int i = 0; i < 2; i++) begin
			host.sendAddr(ALERT_RESP_ADDR, 1'b1);
			#1 check("araAck", addrAck, 8'h1);
			check("araReply", araReply, 8'h1);
			check("araByte", araByte, 8'h81);
			host.sendObs(i ? 8'h80 : 8'h82);
			#1 check("araDone", araReply, 8'h0);
			check("alertRel", alertOe, 8'(i == 0));
		end
	endtask : tAlert

	// Program pin control until a bus voltage command
	task automatic tVprog;
		vprogLevelMv <= 12'h3e8;
		cyc(3);
		check("vprogOn", useVprog, 8'h1);
		vprogLevelMv <= 12'hbb9; // Just above 3 V
		cyc(3);
		check("vprogHigh", useVprog, 8'h0);
		vprogLevelMv <= 12'h3e8;
		cyc(3);
		@(posedge clk_sys);
		voltCmdDone <= 1'b1;
		@(posedge clk_sys);
		voltCmdDone <= 1'b0;
		#1 check("vprogOff", useVprog, 8'h0);
		cyc(10);
		check("vprogGone", useVprog, 8'h0);
	endtask : tVprog

	// I2C start: the long delay keeps main off well past the aux lead
	task automatic tDelay;
		int n;
		inputOkPin <= 1'b1;
		waitFor(0, 1'b1, n);
		cyc(250);
		check("i2cWait", mainEnable, 8'h0);
		inputOkPin <= 1'b0;
		cyc(10);
		check("auxKept", auxiliarySupplyOutput, 8'h1);
	endtask : tDelay

	// Serial-link start: aux lead, ramp length, warning lead on loss
	task automatic tSeq;
		int n;
		inputOkPin <= 1'b1;
		waitFor(0, 1'b1, n);
		waitFor(1, 1'b1, n);
		check("startWait", 8'(n), 8'h14);
		waitFor(2, 1'b0, n);
		check("rampLen", 8'(n), 8'ha);
		inputOkPin <= 1'b0;
		waitFor(3, 1'b1, n);
		check("mainHeld", mainEnable, 8'h1);
		waitFor(1, 1'b0, n);
		check("warnLead", 8'(n), 8'h5);
		cyc(5);
		check("auxHold", auxiliarySupplyOutput, 8'h1);
	endtask : tSeq

	// Indicator blinks only while the input is low
	task automatic tLed;
		int t;
		logic last;
		inputBelow80Pin <= 1'b1;
		cyc(10);
		t = 0;
		last = inputLed;
		for (int i = 0; i < 16; i++) begin
			cyc(1);
			if (inputLed !== last) t++;
			last = inputLed;
		end
		check("blinks", 8'(t), 8'h4);
		inputBelow80Pin <= 1'b0;
		cyc(10);
		check("ledSteady", inputLed, 8'h1);
	endtask : tLed

	// Strap resistor present: serial-link mode, no bus answers
	task automatic tRs485;
		protocolStrapPin <= 1'b1;
		unitLevelMv <= 12'h3fc; // Unit 7
		rackLevelMv <= 12'hb2c; // Rack 8
		doReset();
		check("mode485", rs485Mode, 8'h1);
		check("selTop", addressSelectBits, 8'hf);
		host.sendAddr(7'h4f, 1'b0);
		#1 check("ack485", addrAck, 8'h0);
	endtask : tRs485

	// Main sequence
	initial begin
		nFail = 0;
		checksDone = 0;
		rst = 1'b1;
		unitLevelMv = 12'hce4; // Open pin: invalid position
		rackLevelMv = 12'hcee;
		vprogLevelMv = 12'hce4;
		protocolStrapPin = 1'b0;
		inputOkPin = 1'b0;
		inputBelow80Pin = 1'b0;
		voltCmdDone = 1'b0;
		alertEvent = 1'b0;
		doReset();
		tConfig();
		tAddr();
		tAlert();
		tVprog();
		tDelay();
		tLed();
		tRs485();
		tSeq();
		finishTest();
	end
endmodule : test_rectifier_address_and_sequencing
`default_nettype wire

//--- src/rasq_ctrl.sv
// Address decoding, mode strap, set-point arbitration and power sequencing
// Summary of operation
// - Answer at 100 plus four select bits
// - Address byte low bit: 0 write, 1 read
// - Select bits come from unit and rack inputs
// - Unit level gives ten positions; 3.30 V invalid
// - Rack level gives eight combinations
// - Alert response address answers reads only
// - Open strap I2C, resistor present RS485
// - Program level open or above 3 V ignored
// - Voltage bus command ends program input control
// - I2C mode waits 10 s before main rise
// - I2C mode ramps main over 120 ms
// - Warning 3 ms before main falls below 40 V
// - Auxiliary output leads main regulation by 450 ms (I2C mode: by the 10 s start delay)
// - Blink input LED while input below 80 V
// - Flag invalid command on broadcast read
// - Release alert only when observed address matches
`default_nettype none
module rasq_ctrl
	import rasq_pkg::*;
#(
	parameter logic [31:0] DELAY_CYC = 32'(START_DELAY_CYC),
	parameter logic [31:0] LEAD_CYC = 32'(AUX_LEAD_CYC),
	parameter logic [31:0] RAMP_LEN_CYC = 32'(RAMP_CYC),
	parameter logic [31:0] HOLD_CYC = 32'(HOLD_UP_CYC),
	parameter logic [31:0] WARN_CYC = 32'(WARN_LEAD_CYC),
	parameter logic [31:0] AUX_OFF_CYC = 32'(AUX_HOLD_CYC),
	parameter logic [31:0] BLINK_CYC = 32'(BLINK_HALF_CYC)
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [11:0] unitLevelMv,
	input wire logic [11:0] rackLevelMv,
	input wire logic [11:0] vprogLevelMv,
	input wire logic protocolStrapPin,
	input wire logic inputOkPin,
	input wire logic inputBelow80Pin,
	input wire logic addrByteValid,
	input wire logic [7:0] addrByte,
	input wire logic voltCmdDone,
	input wire logic alertEvent,
	input wire logic obsByteValid,
	input wire logic [7:0] obsByte,
	output logic [3:0] addressSelectBits,
	output logic addressValid,
	output logic rs485Mode,
	output logic addrAck,
	output logic addrIsRead,
	output logic invalidCmd,
	output logic araReply,
	output logic [7:0] araByte,
	output logic alertOe,
	output logic useVprog,
	output logic auxiliarySupplyOutput,
	output logic mainEnable,
	output logic mainRamping,
	output logic powerGoodWarning,
	output logic inputLed
);
	typedef struct packed {
		rasq_seq_t seq;
		logic [31:0] cnt;
		logic [31:0] blinkCnt;
		logic [4:0] settleCnt;
		logic cfgDone;
		logic [3:0] addr;
		logic addrOk;
		logic rs485;
		logic vprogOff;
		logic useVp;
		logic ack;
		logic isRead;
		logic invalid;
		logic araRep;
		logic [7:0] araB;
		logic alert;
		logic aux;
		logic main;
		logic ramp;
		logic pgWarn;
		logic led;
	} rasq_state_t;

	rasq_state_t state_reg;
	rasq_state_t state_next;
	logic [2:0] pinSync;
	logic strapRes;
	logic inputOk;
	logic inputLow;
	logic [4:0] cfgAddr;
	logic [31:0] waitCyc;
	logic [6:0] hitAddr;

	// Strap and supply pins come from outside the clock domain
	rasq_sync #(
		.WIDTH(3)
	) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pinIn({protocolStrapPin, inputOkPin, inputBelow80Pin}),
		.pinOut(pinSync)
	);
	assign strapRes = pinSync[2];
	assign inputOk = pinSync[1];
	assign inputLow = pinSync[0];

	// Unit position 1..10 from level, 0 when invalid
	function automatic logic [3:0] unitPos(input logic [11:0] mv);
		logic [3:0] pos;
		logic [11:0] nom;
		pos = 4'h0;
		for (int n = 1; n <= UNIT_POSITIONS; n++) begin
			nom = UNIT_TOP_MV - 12'(n * UNIT_STEP_MV);
			if (mv <= nom + (UNIT_STEP_MV >> 1) && mv > UNIT_INVALID_MV - 12'(
				n * UNIT_STEP_MV) - 12'(UNIT_STEP_MV >> 1) + 12'h001) begin
				pos = 4'(n);
			end
		end
		if (mv <= (UNIT_STEP_MV >> 1)) begin
			pos = 4'(UNIT_POSITIONS);
		end
		return pos;
	endfunction : unitPos

	// Rack combination 1..8 within tolerance window, 0 when none
	function automatic logic [3:0] rackPos(input logic [11:0] mv);
		logic [3:0] pos;
		int lo;
		int hi;
		pos = 4'h0;
		for (int n = 0; n < RACK_COMBOS; n++) begin
			lo = int'(RACK_MV[n]) * (100 - RACK_TOL_PCT) / 100;
			hi = int'(RACK_MV[n]) * (100 + RACK_TOL_PCT) / 100;
			if (int'(mv) >= lo && int'(mv) <= hi) begin
				pos = 4'(n + 1);
			end
		end
		return pos;
	endfunction : rackPos

	// Select bits from unit and rack, bit 4 set when the pair is valid
	function automatic logic [4:0] selBits(input logic [3:0] u,
		input logic [3:0] r);
		logic [4:0] res;
		res = 5'h00;
		if (u >= 4'h1 && u <= 4'h4 && r >= 4'h1 && r <= 4'h4) begin
			res = {1'b1, 4'((r - 4'h1) * 4'h4 + (u - 4'h1))};
		end else if (u >= 4'h1 && u <= 4'h5 && r >= 4'h6) begin
			res = {1'b1, 4'((r - 4'h6) * 4'h5 + (u - 4'h1))};
		end else if ((u == 4'h6 || u == 4'h7) && r >= 4'h1) begin
			res = {1'b1, 4'((r - 4'h1) * 4'h2 + (u - 4'h6))};
		end else if (u >= 4'h8 && u <= 4'ha && r >= 4'h4) begin
			res = {1'b1, 4'((r - 4'h4) * 4'h3 + (u - 4'h8))};
		end
		return res;
	endfunction : selBits

	assign cfgAddr = selBits(unitPos(unitLevelMv), rackPos(rackLevelMv));
	assign hitAddr = addrByte[7:1];
	// Auxiliary lead must also be met when the start delay is shorter
	assign waitCyc = (state_reg.rs485 || LEAD_CYC > DELAY_CYC) ? LEAD_CYC :
		DELAY_CYC;

	always_comb begin
		state_next = state_reg;
		state_next.ack = 1'b0;
		state_next.invalid = 1'b0;
		// Configuration capture after settling; retry until unit and rack give a valid address
		if (state_reg.settleCnt != SETTLE_CYC) begin
			state_next.settleCnt = state_reg.settleCnt + 5'h01;
		end else if (!state_reg.addrOk) begin
			if (!state_reg.cfgDone) begin
				state_next.rs485 = strapRes;
			end
			state_next.cfgDone = 1'b1;
			state_next.addr = cfgAddr[3:0];
			state_next.addrOk = cfgAddr[4];
		end
		// Address phase decode; only the I2C personality answers here
		if (addrByteValid && !state_reg.rs485 && state_reg.cfgDone) begin
			state_next.isRead = addrByte[0];
			if (hitAddr == {UNIT_ADDR_HI, state_reg.addr}
				&& state_reg.addrOk) begin
				state_next.ack = 1'b1;
			end else if (hitAddr == BROADCAST_ADDR) begin
				state_next.ack = !addrByte[0];
				state_next.invalid = addrByte[0];
			end else if (hitAddr == ALERT_RESP_ADDR) begin
				// Writes to this address are not acknowledged
				if (addrByte[0] && state_reg.alert && state_reg.addrOk) begin
					state_next.ack = 1'b1;
					state_next.araRep = 1'b1;
					state_next.araB = {UNIT_ADDR_HI, state_reg.addr, 1'b1};
				end
			end
		end
		// Alert release only on an observed byte naming this unit
		if (obsByteValid && state_reg.araRep) begin
			state_next.araRep = 1'b0;
			if (obsByte[7:1] == {UNIT_ADDR_HI, state_reg.addr}) begin
				state_next.alert = 1'b0;
			end
		end
		// A new event wins over a release in the same cycle
		if (alertEvent) begin
			state_next.alert = 1'b1;
		end
		// Program pin dropped for good after any voltage command
		if (voltCmdDone) begin
			state_next.vprogOff = 1'b1;
		end
		state_next.useVp = !state_next.vprogOff
			&& vprogLevelMv <= VPROG_MAX_MV;
		// Input LED blinks while input is low, steady otherwise
		if (inputLow) begin
			if (state_reg.blinkCnt >= BLINK_CYC - 32'h1) begin
				state_next.blinkCnt = '0;
				state_next.led = !state_reg.led;
			end else begin
				state_next.blinkCnt = state_reg.blinkCnt + 32'h1;
			end
		end else begin
			state_next.blinkCnt = '0;
			state_next.led = 1'b1;
		end
		// Power sequencing
		state_next.cnt = state_reg.cnt + 32'h1;
		case (state_reg.seq)
			SQ_OFF: begin
				state_next.cnt = '0;
				if (inputOk && state_reg.cfgDone) begin
					state_next.seq = SQ_WAIT;
					state_next.aux = 1'b1;
				end
			end
			SQ_WAIT: begin
				if (!inputOk) begin
					state_next.seq = SQ_AUX;
					state_next.cnt = '0;
				end else if (state_reg.cnt >= waitCyc - 32'h1) begin
					state_next.seq = SQ_RAMP;
					state_next.cnt = '0;
					state_next.main = 1'b1;
					state_next.ramp = 1'b1;
				end
			end
			SQ_RAMP, SQ_ON: begin
				if (!inputOk) begin
					state_next.seq = SQ_HOLD;
					state_next.cnt = '0;
					state_next.ramp = 1'b0;
				end else if (state_reg.seq == SQ_RAMP
					&& state_reg.cnt >= RAMP_LEN_CYC - 32'h1) begin
					state_next.seq = SQ_ON;
					state_next.ramp = 1'b0;
				end
			end
			SQ_HOLD: begin
				// Warning leads the end of hold-up by the warning time
				if (state_reg.cnt == HOLD_CYC - WARN_CYC - 32'h1) begin
					state_next.pgWarn = 1'b1;
				end
				if (inputOk) begin
					state_next.seq = SQ_WAIT;
					state_next.cnt = '0;
					state_next.pgWarn = 1'b0;
					state_next.main = 1'b0;
				end else if (state_reg.cnt >= HOLD_CYC - 32'h1) begin
					state_next.seq = SQ_AUX;
					state_next.cnt = '0;
					state_next.main = 1'b0;
				end
			end
			SQ_AUX: begin
				if (inputOk) begin
					state_next.seq = SQ_WAIT;
					state_next.cnt = '0;
					state_next.pgWarn = 1'b0;
				end else if (state_reg.cnt >= AUX_OFF_CYC - 32'h1) begin
					state_next.seq = SQ_OFF;
					state_next.aux = 1'b0;
					state_next.pgWarn = 1'b0;
				end
			end
			default: begin
				state_next.seq = SQ_OFF;
			end
		endcase
	end

	// Single state register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign addressSelectBits = state_reg.addr;
	assign addressValid = state_reg.addrOk;
	assign rs485Mode = state_reg.rs485;
	assign addrAck = state_reg.ack;
	assign addrIsRead = state_reg.isRead;
	assign invalidCmd = state_reg.invalid;
	assign araReply = state_reg.araRep;
	assign araByte = state_reg.araB;
	assign alertOe = state_reg.alert;
	assign useVprog = state_reg.useVp;
	assign auxiliarySupplyOutput = state_reg.aux;
	assign mainEnable = state_reg.main;
	assign mainRamping = state_reg.ramp;
	assign powerGoodWarning = state_reg.pgWarn;
	assign inputLed = state_reg.led;

	// Checks
	a_unit_ack: assert property (@(posedge clk_sys) disable iff (rst)
		addrAck && !addrIsRead |-> addressValid || araReply
		|| $past(addrByte[7:1]) == BROADCAST_ADDR)
		else $error("write ack without valid target");
	a_rw_bit: assert property (@(posedge clk_sys) disable iff (rst)
		addrByteValid && !rs485Mode && state_reg.cfgDone
		|=> addrIsRead == $past(addrByte[0]))
		else $error("direction bit not taken");
	a_ara_write: assert property (@(posedge clk_sys) disable iff (rst)
		addrByteValid && addrByte == {ALERT_RESP_ADDR, 1'b0}
		|=> !addrAck)
		else $error("write to alert address acknowledged");
	a_bcast_read: assert property (@(posedge clk_sys) disable iff (rst)
		addrByteValid && addrByte == 8'h01 && !rs485Mode
		&& state_reg.cfgDone |=> invalidCmd && !addrAck)
		else $error("broadcast read not flagged");
	a_cfg_hold: assert property (@(posedge clk_sys) disable iff (rst)
		addressValid |=> $stable(addressSelectBits) && $stable(rs485Mode))
		else $error("address changed after capture");
	a_vprog_off: assert property (@(posedge clk_sys) disable iff (rst)
		voltCmdDone |=> ##1 !useVprog [*8])
		else $error("program input followed after command");
	a_alert_keep: assert property (@(posedge clk_sys) disable iff (rst)
		obsByteValid && araReply && !alertEvent
		&& obsByte[7:1] != {UNIT_ADDR_HI, addressSelectBits}
		|=> alertOe)
		else $error("alert released on foreign address");
	a_ramp_len: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(mainRamping) |-> mainRamping [*8])
		else $error("ramp ended too soon");
	a_aux_first: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(mainEnable) |-> auxiliarySupplyOutput
		&& $past(state_reg.cnt) >= LEAD_CYC - 32'h1)
		else $error("main rose before auxiliary lead");
	a_warn_main: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(powerGoodWarning) |-> mainEnable && !$past(inputOk))
		else $error("warning without main on input loss");
	a_led_steady: assert property (@(posedge clk_sys) disable iff (rst)
		!inputLow [*2] |=> inputLed)
		else $error("LED blinks with good input");
	c_main_on: cover property (@(posedge clk_sys) disable iff (rst)
		$rose(mainEnable));
	c_warn: cover property (@(posedge clk_sys) disable iff (rst)
		$rose(powerGoodWarning));
	c_ara_release: cover property (@(posedge clk_sys) disable iff (rst)
		$fell(alertOe));
	c_bcast_bad: cover property (@(posedge clk_sys) disable iff (rst)
		invalidCmd);
endmodule : rasq_ctrl
`default_nettype wire

//--- src/rasq_pkg.sv
// Constants and types shared by the rectifier address and sequencing logic
`default_nettype none
package rasq_pkg;
	// Clock rate and derived cycles per millisecond
	localparam longint CLK_MHZ = 250;
	localparam longint CYC_PER_MS = CLK_MHZ * 1000;
	// Sequencing times in milliseconds
	localparam longint START_DELAY_MS = 10000;
	localparam longint RAMP_MS = 120;
	localparam longint WARN_LEAD_MS = 3;
	localparam longint HOLD_UP_MS = 15;
	localparam longint AUX_LEAD_MS = 450;
	localparam longint AUX_HOLD_MS = 1000;
	localparam longint BLINK_HALF_MS = 250;
	// Cycle counts derived from the times above
	localparam longint START_DELAY_CYC = START_DELAY_MS * CYC_PER_MS;
	localparam longint RAMP_CYC = RAMP_MS * CYC_PER_MS;
	localparam longint WARN_LEAD_CYC = WARN_LEAD_MS * CYC_PER_MS;
	localparam longint HOLD_UP_CYC = HOLD_UP_MS * CYC_PER_MS;
	localparam longint AUX_LEAD_CYC = AUX_LEAD_MS * CYC_PER_MS;
	localparam longint AUX_HOLD_CYC = AUX_HOLD_MS * CYC_PER_MS;
	localparam longint BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;
	// Cycles allowed for the position and strap levels to settle
	localparam logic [4:0] SETTLE_CYC = 5'h10;
	// Bus addresses, 7-bit form
	localparam logic [2:0] UNIT_ADDR_HI = 3'h4;
	localparam logic [6:0] BROADCAST_ADDR = 7'h00;
	localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
	// Level thresholds in millivolts, rack tolerance in percent, unit and rack position counts
	localparam logic [11:0] UNIT_INVALID_MV = 12'hc4e;
	localparam logic [11:0] UNIT_STEP_MV = 12'h14a;
	localparam logic [11:0] UNIT_TOP_MV = 12'hce4;
	localparam logic [11:0] VPROG_MAX_MV = 12'hbb8;
	localparam int RACK_TOL_PCT = 5;
	localparam int UNIT_POSITIONS = 10;
	localparam int RACK_COMBOS = 8;
	// Nominal rack levels in millivolts, combination 1 first
	localparam logic [11:0] RACK_MV [RACK_COMBOS] = '{12'hcee, 12'h42e,
		12'h761, 12'h244, 12'h67c, 12'h348, 12'h58c, 12'hb2c};
	// Power sequencing states
	typedef enum logic [2:0] {
		SQ_OFF, SQ_WAIT, SQ_RAMP, SQ_ON, SQ_HOLD, SQ_AUX
	} rasq_seq_t;
endpackage : rasq_pkg
`default_nettype wire

//--- src/rasq_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`default_nettype none
module rasq_sync #(
	parameter int WIDTH = 1
) (
	clk_sys,
	rst,
	pinIn,
	pinOut
);
	input wire logic clk_sys;
	input wire logic rst;
	input wire logic [WIDTH-1:0] pinIn;
	output logic [WIDTH-1:0] pinOut;

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} rasq_sync_t;

	rasq_sync_t state_reg;
	rasq_sync_t state_next;

	// Stage one feeds only stage two; the agreement check sees two and three
	always_comb begin
		state_next = state_reg;
		state_next.s1 = pinIn;
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (state_reg.s2[i] == state_reg.s3[i]) begin
				state_next.q[i] = state_reg.s3[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign pinOut = state_reg.q;
endmodule : rasq_sync
`default_nettype wire
